// ==== odsc_regs.vh ====
// Constants of the octal driver serial command and diagnosis block.
// Assumes inclusion by bare name from the design files of this folder.
`ifndef ODSC_REGS_VH
`define ODSC_REGS_VH

// ----------------------------------------------------------------------
// Command word layout
// ----------------------------------------------------------------------
`define ODSC_WORD_W        16
`define ODSC_CNT_W         4
`define ODSC_LAST_BIT      4'hf
`define ODSC_CNT_ZERO      4'h0
`define ODSC_CNT_ONE       4'h1
`define ODSC_KEY_HI        15
`define ODSC_KEY_LO        12
`define ODSC_MODE_HI       11
`define ODSC_MODE_LO       8
`define ODSC_DATA_HI       7
`define ODSC_DATA_LO       0
`define ODSC_KEY_VALUE     4'ha
`define ODSC_MODE_OUTPUT   4'hc
`define ODSC_MODE_DIAG     4'h3
`define ODSC_MODE_PROTECT  4'ha

// ----------------------------------------------------------------------
// Channels and fault codes
// ----------------------------------------------------------------------
`define ODSC_CHANNELS      8
`define ODSC_PAR_FIRST     5
`define ODSC_PAR_W         3
`define ODSC_FAULT_NONE    2'h0
`define ODSC_FAULT_OVC     2'h3
`define ODSC_FAULT_ALL     16'hffff
`define ODSC_RESET_BYTE    8'h00
`define ODSC_RESET_WORD    16'h0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// Both counts are twenty microseconds of the 100 ns clock, sized to the
// timer so that no default is cut down from a wider integer.
`define ODSC_POR_QUAL_CYC   8'hc8
`define ODSC_THERM_FILT_CYC 8'hc8
`define ODSC_TIMER_W        8

`endif

// ==== odsc_sync.v ====
// Two-stage synchroniser for a group of unrelated level inputs.
// Assumes each bit is a slow level; no word coherence is implied.
module odsc_sync #(
	parameter W = 1
) (
	input  wire         clk_i,
	input  wire         resetn_i,
	input  wire [W-1:0] async_i,
	output reg  [W-1:0] sync_o
);

	reg [W-1:0] meta_q;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_q <= {W{1'b0}};
			sync_o <= {W{1'b0}};
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule

// ==== odsc_filt.v ====
// Qualification filter: output rises after the input has stayed high
// for LEN consecutive clocks and falls as soon as the input falls.
// Assumes a synchronised input.
`include "odsc_regs.vh"

module odsc_filt #(
	parameter [`ODSC_TIMER_W-1:0] LEN = 8'h01
) (
	input  wire clk_i,
	input  wire resetn_i,
	input  wire level_i,
	output reg  qual_o
);

	reg [`ODSC_TIMER_W-1:0] cnt_q;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q  <= {`ODSC_TIMER_W{1'b0}};
			qual_o <= 1'b0;
		end else if (!level_i) begin
			cnt_q  <= {`ODSC_TIMER_W{1'b0}};
			qual_o <= 1'b0;
		end else if (cnt_q == LEN - 1'b1) begin
			qual_o <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

endmodule

// ==== odsc_top.v ====
// Serial command and diagnosis logic of an eight-channel power driver.
// Assumes a slow serial master: the 10 MHz clock oversamples its clock.
`include "odsc_regs.vh"

module odsc_top #(
	// Supply qualification and thermal filter lengths, in clocks; a bench
	// may shorten the filter to keep runs brief.
	parameter [`ODSC_TIMER_W-1:0] POR_QUAL_CYC   = `ODSC_POR_QUAL_CYC,
	parameter [`ODSC_TIMER_W-1:0] THERM_FILT_CYC = `ODSC_THERM_FILT_CYC
) (
	input  wire                       clk_i,
	input  wire                       resetn_i,
	input  wire                       spi_cs_n_i,
	input  wire                       spi_sclk_i,
	input  wire                       spi_sdi_i,
	output reg                        spi_sdo_o,
	output reg                        spi_sdo_oe_o,
	input  wire                       supply_above_trip_i,
	input  wire                       hardware_clear_input_n_i,
	input  wire [`ODSC_PAR_W-1:0]     parallel_enable_inputs_i,
	input  wire [`ODSC_CHANNELS-1:0]  overtemp_raw_i,
	input  wire [`ODSC_WORD_W-1:0]    fault_code_i,
	output reg  [`ODSC_CHANNELS-1:0]  power_channel_o,
	output reg  [`ODSC_CHANNELS-1:0]  diag_latch_o,
	output reg  [`ODSC_CHANNELS-1:0]  ovc_linear_o,
	output reg  [`ODSC_CHANNELS-1:0]  thermal_shutdown_o
);

	localparam SYNC_W = 1 + 1 + 1 + 1 + 1 + `ODSC_PAR_W + `ODSC_CHANNELS + `ODSC_WORD_W;

	// ------------------------------------------------------------------
	// Key check, used when applying a word and when clearing faults
	// ------------------------------------------------------------------
	function word_keyed;
		input [`ODSC_WORD_W-1:0] word;
		begin
			word_keyed = (word[`ODSC_KEY_HI:`ODSC_KEY_LO] == `ODSC_KEY_VALUE);
		end
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------------
	wire [SYNC_W-1:0]          sync_w;
	wire                       cs_n_s;
	wire                       sclk_s;
	wire                       sdi_s;
	wire                       supply_s;
	wire                       clr_n_s;
	wire [`ODSC_PAR_W-1:0]     par_s;
	wire [`ODSC_CHANNELS-1:0]  otemp_s;
	wire [`ODSC_WORD_W-1:0]    code_s;

	odsc_sync #(
		.W (SYNC_W)
	) u_sync (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.async_i  ({spi_cs_n_i, spi_sclk_i, spi_sdi_i, supply_above_trip_i,
			hardware_clear_input_n_i, parallel_enable_inputs_i, overtemp_raw_i,
			fault_code_i}),
		.sync_o   (sync_w)
	);

	assign {cs_n_s, sclk_s, sdi_s, supply_s, clr_n_s, par_s, otemp_s, code_s} = sync_w;

	// ------------------------------------------------------------------
	// Supply qualification and global clear
	// ------------------------------------------------------------------
	reg [`ODSC_TIMER_W-1:0] por_cnt_q;
	reg                     por_done_q;
	wire                    clear_all;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			por_cnt_q  <= {`ODSC_TIMER_W{1'b0}};
			por_done_q <= 1'b0;
		end else if (!supply_s) begin
			por_cnt_q  <= {`ODSC_TIMER_W{1'b0}};
			por_done_q <= 1'b0;
		end else if (por_cnt_q == POR_QUAL_CYC - 1'b1) begin
			por_done_q <= 1'b1;
		end else begin
			por_cnt_q <= por_cnt_q + 1'b1;
		end
	end

	// Serial state, mode registers and fault slots stay cleared, and every
	// channel off, until the supply has been qualified and while the clear pin is low.
	assign clear_all = !por_done_q || !clr_n_s;

	// ------------------------------------------------------------------
	// Thermal filters
	// ------------------------------------------------------------------
	wire [`ODSC_CHANNELS-1:0] therm_w;

	genvar g;
	generate
		for (g = 0; g < `ODSC_CHANNELS; g = g + 1) begin : g_therm
			odsc_filt #(
				.LEN (THERM_FILT_CYC)
			) u_filt (
				.clk_i    (clk_i),
				.resetn_i (resetn_i),
				.level_i  (otemp_s[g]),
				.qual_o   (therm_w[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// Serial edges
	// ------------------------------------------------------------------
	reg  cs_n_d_q;
	reg  sclk_d_q;
	wire cs_fall;
	wire cs_rise;
	wire sclk_rise;
	wire sclk_fall;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cs_n_d_q <= 1'b1;
			sclk_d_q <= 1'b0;
		end else begin
			cs_n_d_q <= cs_n_s;
			sclk_d_q <= sclk_s;
		end
	end

	assign cs_fall   = cs_n_d_q && !cs_n_s;
	assign cs_rise   = !cs_n_d_q && cs_n_s;
	assign sclk_rise = !cs_n_s && !sclk_d_q && sclk_s;
	assign sclk_fall = !cs_n_s && sclk_d_q && !sclk_s;

	// ------------------------------------------------------------------
	// Shift state
	// ------------------------------------------------------------------
	reg  [`ODSC_WORD_W-1:0]   in_sh_q;
	reg  [`ODSC_WORD_W-1:0]   delay_q;
	reg  [`ODSC_WORD_W-1:0]   word_q;
	reg  [`ODSC_CNT_W-1:0]    bit_cnt_q;
	reg                       word_seen_q;
	reg  [`ODSC_CHANNELS-1:0] cmd_on_q;
	wire [`ODSC_WORD_W-1:0]   in_next;
	wire [`ODSC_WORD_W-1:0]   fault_now;
	wire [`ODSC_WORD_W-1:0]   load_word;
	wire                      keyed;
	wire                      fault_clr;

	assign in_next   = {sdi_s, in_sh_q[`ODSC_WORD_W-1:1]};
	assign keyed     = word_seen_q && word_keyed(word_q);
	assign fault_clr = cs_rise && keyed && (bit_cnt_q == `ODSC_CNT_ZERO);
	assign load_word = (|therm_w) ? `ODSC_FAULT_ALL : fault_now;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			in_sh_q      <= `ODSC_RESET_WORD;
			delay_q      <= `ODSC_RESET_WORD;
			word_q       <= `ODSC_RESET_WORD;
			bit_cnt_q    <= `ODSC_CNT_ZERO;
			word_seen_q  <= 1'b0;
			spi_sdo_o    <= 1'b0;
			spi_sdo_oe_o <= 1'b0;
			cmd_on_q     <= `ODSC_RESET_BYTE;
			diag_latch_o <= `ODSC_RESET_BYTE;
			ovc_linear_o <= `ODSC_RESET_BYTE;
		end else if (clear_all) begin
			in_sh_q      <= `ODSC_RESET_WORD;
			delay_q      <= `ODSC_RESET_WORD;
			word_q       <= `ODSC_RESET_WORD;
			bit_cnt_q    <= `ODSC_CNT_ZERO;
			word_seen_q  <= 1'b0;
			spi_sdo_o    <= 1'b0;
			spi_sdo_oe_o <= 1'b0;
			cmd_on_q     <= `ODSC_RESET_BYTE;
			diag_latch_o <= `ODSC_RESET_BYTE;
			ovc_linear_o <= `ODSC_RESET_BYTE;
		end else if (cs_fall) begin
			delay_q      <= load_word;
			spi_sdo_o    <= load_word[0];
			spi_sdo_oe_o <= 1'b1;
			bit_cnt_q    <= `ODSC_CNT_ZERO;
			word_seen_q  <= 1'b0;
		end else if (cs_rise) begin
			spi_sdo_oe_o <= 1'b0;
			if (keyed) begin
				// Only the group named by the mode nibble changes.
				case (word_q[`ODSC_MODE_HI:`ODSC_MODE_LO])
				`ODSC_MODE_OUTPUT: begin
					cmd_on_q <= word_q[`ODSC_DATA_HI:`ODSC_DATA_LO];
				end
				`ODSC_MODE_DIAG: begin
					diag_latch_o <= word_q[`ODSC_DATA_HI:`ODSC_DATA_LO];
				end
				`ODSC_MODE_PROTECT: begin
					ovc_linear_o <= word_q[`ODSC_DATA_HI:`ODSC_DATA_LO];
				end
				default: begin
					cmd_on_q <= cmd_on_q;
				end
				endcase
			end
		end else if (sclk_rise) begin
			// Input taken on the rising edge; the delay line holds the fault
			// word first and then the received bits, sixteen edges behind.
			in_sh_q   <= in_next;
			delay_q   <= {sdi_s, delay_q[`ODSC_WORD_W-1:1]};
			bit_cnt_q <= bit_cnt_q + `ODSC_CNT_ONE;
			if (bit_cnt_q == `ODSC_LAST_BIT) begin
				// A word only counts once all sixteen bits are in.
				word_q      <= in_next;
				word_seen_q <= 1'b1;
			end
		end else if (sclk_fall) begin
			spi_sdo_o <= delay_q[0];
		end
	end

	// ------------------------------------------------------------------
	// Fault register and channel drive
	// ------------------------------------------------------------------
	generate
		for (g = 0; g < `ODSC_CHANNELS; g = g + 1) begin : g_chan
			reg  [1:0] slot_q;
			wire [1:0] live;
			wire       ovc_evt;
			wire       hold_evt;
			wire       par_on;

			assign live     = code_s[2*g+1:2*g];
			assign ovc_evt  = (live == `ODSC_FAULT_OVC) && !ovc_linear_o[g];
			assign hold_evt = diag_latch_o[g] && (live != `ODSC_FAULT_NONE)
				&& (slot_q == `ODSC_FAULT_NONE);

			// Overcurrent overwrites unless the channel is in linear mode; a set in the clear cycle wins.
			always @(posedge clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					slot_q <= `ODSC_FAULT_NONE;
				end else if (clear_all) begin
					slot_q <= `ODSC_FAULT_NONE;
				end else if (ovc_evt) begin
					slot_q <= `ODSC_FAULT_OVC;
				end else if (hold_evt) begin
					slot_q <= live;
				end else if (fault_clr) begin
					slot_q <= `ODSC_FAULT_NONE;
				end
			end

			// Non-latching channels report open load and short as seen now.
			assign fault_now[2*g+1:2*g] = (diag_latch_o[g] || slot_q == `ODSC_FAULT_OVC)
				? slot_q : live;

			if (g >= `ODSC_PAR_FIRST) begin : g_par
				assign par_on = par_s[g-`ODSC_PAR_FIRST];
			end else begin : g_nopar
				assign par_on = 1'b0;
			end

			// A filtered thermal event drops the channel; it comes back on
			// by itself once the filter releases, unless commanded off.
			always @(posedge clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					power_channel_o[g]    <= 1'b0;
					thermal_shutdown_o[g] <= 1'b0;
				end else begin
					power_channel_o[g] <= !clear_all && (cmd_on_q[g] || par_on)
						&& !therm_w[g]
						&& !(slot_q == `ODSC_FAULT_OVC && !ovc_linear_o[g]);
					thermal_shutdown_o[g] <= therm_w[g];
				end
			end
		end
	endgenerate

endmodule

// ==== odsc_checker.sv ====
// Concurrent checks of the serial command and diagnosis block.
// Assumes binding to odsc_top and a serial clock far slower than clk_i.
module odsc_checker #(
	parameter [7:0] POR_QUAL_CYC = 8'hc8
) (
	input wire        clk_i,
	input wire        resetn_i,
	input wire        spi_cs_n_i,
	input wire        spi_sclk_i,
	input wire        spi_sdo_o,
	input wire        spi_sdo_oe_o,
	input wire        supply_above_trip_i,
	input wire        hardware_clear_input_n_i,
	input wire [2:0]  parallel_enable_inputs_i,
	input wire [7:0]  overtemp_raw_i,
	input wire [15:0] fault_code_i,
	input wire [7:0]  power_channel_o,
	input wire [7:0]  diag_latch_o,
	input wire [7:0]  ovc_linear_o,
	input wire [7:0]  thermal_shutdown_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// Qualified supply tracking
	// ------------------------------------------------------------
	// The margin of eight covers the input synchronisers of the block.
	logic [8:0] up_cnt_q;
	logic [8:0] up_cnt_d;
	logic       ready;
	assign up_cnt_d = !(supply_above_trip_i && hardware_clear_input_n_i) ? 9'h000 :
		(up_cnt_q == 9'h1ff) ? up_cnt_q : up_cnt_q + 9'h001;
	assign ready = up_cnt_q > ({1'b0, POR_QUAL_CYC} + 9'h008);
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			up_cnt_q <= 9'h000;
		end else begin
			up_cnt_q <= up_cnt_d;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	sequence cs_risen;
		$rose(spi_cs_n_i) ##1 spi_cs_n_i [*5];
	endsequence
	sequence cs_fallen;
		$fell(spi_cs_n_i) ##1 !spi_cs_n_i [*5];
	endsequence
	a_oe_release: assert property (cs_risen |-> !spi_sdo_oe_o)
		else $error("data out still driven after select rise");
	a_oe_drive: assert property (cs_fallen |-> spi_sdo_oe_o || !ready)
		else $error("data out not driven while selected");
	a_sdo_on_fall: assert property (
		spi_sdo_oe_o && $past(spi_sdo_oe_o) && $changed(spi_sdo_o) |-> !$past(spi_sclk_i, 2))
		else $error("data out changed away from a clock fall");
	a_clear_pin_off: assert property (
		!hardware_clear_input_n_i [*5] |-> power_channel_o == 8'h00
		&& diag_latch_o == 8'h00 && ovc_linear_o == 8'h00)
		else $error("clear pin did not clear the channels");
	a_therm_cause: assert property (
		(thermal_shutdown_o & ~$past(overtemp_raw_i, 5)) == 8'h00)
		else $error("thermal shutdown without a hot channel");
	a_therm_off: assert property (
		(thermal_shutdown_o & $past(thermal_shutdown_o) & power_channel_o) == 8'h00)
		else $error("channel on during thermal shutdown");
	a_cfg_at_rise: assert property (
		$changed({diag_latch_o, ovc_linear_o}) && hardware_clear_input_n_i
		|-> spi_cs_n_i && $past(spi_cs_n_i, 2))
		else $error("mode registers changed outside select rise");
	a_par_enable: assert property (
		(hardware_clear_input_n_i && overtemp_raw_i == 8'h00
		&& fault_code_i == 16'h0000 && parallel_enable_inputs_i == 3'h7) [*6]
		|-> !ready || power_channel_o[7:5] == 3'h7)
		else $error("parallel enable did not turn channels on");
endmodule

bind odsc_top odsc_checker #(
	.POR_QUAL_CYC(POR_QUAL_CYC)
) u_chk (
	.clk_i, .resetn_i, .spi_cs_n_i, .spi_sclk_i, .spi_sdo_o, .spi_sdo_oe_o,
	.supply_above_trip_i, .hardware_clear_input_n_i, .parallel_enable_inputs_i,
	.overtemp_raw_i, .fault_code_i, .power_channel_o, .diag_latch_o, .ovc_linear_o,
	.thermal_shutdown_o
);

// ==== odsc_host.sv ====
// Host model: serial master driving select, serial clock and data in.
// Assumes clk_i at 100 ns; the serial clock is 5 clocks low, 3 high.
module odsc_host (
	input  wire  clk_i,
	input  wire  sdo_i,
	output logic cs_n_o,
	output logic sclk_o,
	output logic sdi_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Data in rests high like its pull-up; the clock stands still between frames.
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o = 1'b1;
	end
	task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
		rx = 32'h0000_0000;
		@(posedge clk_i) cs_n_o <= 1'b0;
		repeat (3) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i) sdi_o <= tx[i];
			repeat (4) @(posedge clk_i);
			rx[i] = sdo_i;
			sclk_o <= 1'b1;
			repeat (3) @(posedge clk_i);
			sclk_o <= 1'b0;
		end
		repeat (5) @(posedge clk_i);
		cs_n_o <= 1'b1;
		sdi_o <= 1'b1;
		repeat (8) @(posedge clk_i);
	endtask
endmodule

// ==== tb.sv ====
// Self-checking bench of the serial command and diagnosis block.
// Assumes odsc_top, odsc_host and the bound checker in the same folder.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        supply_i = 1'b0;
	logic        clear_n_i = 1'b1;
	logic [2:0]  par_i = 3'h0;
	logic [7:0]  hot_i = 8'h00;
	logic [15:0] fault_i = 16'h0000;
	logic [31:0] rx;
	logic [7:0]  out_e = 8'h00;
	logic [7:0]  diag_e = 8'h00;
	logic [7:0]  lin_e = 8'h00;
	logic [3:0]  modes [4] = '{4'hc, 4'h3, 4'ha, 4'h5};
	logic [7:0]  vals [4] = '{8'h5a, 8'hc3, 8'h96, 8'hff};
	int          bad_count = 0;
	int          total_checks = 0;
	int          cyc = 0;
	wire         cs_n, sclk, sdi, sdo, sdo_oe, sdo_w;
	wire [7:0]   pwr, diag, lin, therm;
	always #50 clk_i = ~clk_i;
	// The data out line floats whenever the device lets go of it.
	assign sdo_w = sdo_oe ? sdo : 1'bz;
	odsc_top #(.POR_QUAL_CYC(8'hc8), .THERM_FILT_CYC(8'h06)) uut (
		.clk_i(clk_i), .resetn_i(resetn_i), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk),
		.spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .supply_above_trip_i(supply_i),
		.hardware_clear_input_n_i(clear_n_i), .parallel_enable_inputs_i(par_i),
		.overtemp_raw_i(hot_i), .fault_code_i(fault_i), .power_channel_o(pwr),
		.diag_latch_o(diag), .ovc_linear_o(lin), .thermal_shutdown_o(therm)
	);
	odsc_host host (.clk_i(clk_i), .sdo_i(sdo_w), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] w, input logic [15:0] f);
		host.xfer({16'h0000, w}, 16, rx);
		chk(rx[15:0], f);
		chk({31'h0000_0000, sdo_oe}, 32'h0000_0000);
	endtask
	task automatic regs;
		chk({pwr, diag, lin}, {out_e, diag_e, lin_e});
	endtask
	task automatic test_done;
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 8000) begin
			bad_count++;
			test_done();
		end
	end
	initial begin
		repeat (10) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		chk({pwr, diag, lin, therm}, 32'h0000_0000);
		supply_i <= 1'b1;
		host.xfer(32'h0000_acff, 16, rx);
		chk(pwr, 8'h00);
		fault_i <= 16'h9a65;
		repeat (80) @(posedge clk_i);
		wr(16'hac00, 16'h9a65);
		fault_i <= 16'h0000;
		for (int m = 0; m < 4; m++) begin
			wr({4'ha, modes[m], vals[m]}, 16'h0000);
			case (modes[m])
				4'hc: out_e = vals[m];
				4'h3: diag_e = vals[m];
				4'ha: lin_e = vals[m];
				default: ;
			endcase
			regs();
		end
		wr(16'h5cff, 16'h0000);
		regs();
		host.xfer({16'hac0f, 16'h1234}, 32, rx);
		chk(rx, 32'h1234_0000);
		out_e = 8'h0f;
		regs();
		host.xfer(32'h0000_acff, 12, rx);
		regs();
		fault_i <= 16'h0002;
		repeat (6) @(posedge clk_i);
		fault_i <= 16'h0000;
		host.xfer(32'h00ff_ac0f, 24, rx);
		chk(rx[15:0], 16'h0002);
		wr(16'h5c0f, 16'h0002);
		wr(16'hac0f, 16'h0002);
		wr(16'hac0f, 16'h0000);
		hot_i <= 8'h04;
		repeat (20) @(posedge clk_i);
		chk({therm, pwr}, {8'h04, 8'h0b});
		wr(16'hac0f, 16'hffff);
		hot_i <= 8'h00;
		repeat (10) @(posedge clk_i);
		chk({therm, pwr}, {8'h00, 8'h0f});
		wr(16'hac0f, 16'h0000);
		wr(16'hac00, 16'h0000);
		par_i <= 3'h7;
		repeat (8) @(posedge clk_i);
		chk(pwr, 8'he0);
		par_i <= 3'h0;
		clear_n_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		{out_e, diag_e, lin_e} = 24'h00_0000;
		regs();
		clear_n_i <= 1'b1;
		test_done();
	end
endmodule
